// ### verilog/p1g_port.sv
// p1g_port: port 1 register slice with match, latch, input and output mode.
// assumes a single-cycle register bus from the core and pins synchronous to clk_i;
// the mask register lives in the wake logic and arrives on mask_i.
`timescale 1ns/1ns

module p1g_port (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [p1g_pkg::P1G_ADDR_W-1:0] sfr_addr_i,
   input wire logic [p1g_pkg::P1G_PAGE_W-1:0] sfr_page_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [p1g_pkg::P1G_PIN_W-1:0] sfr_wdata_i,
   input wire logic sfr_bit_wr_i,
   input wire logic [2:0] sfr_bit_sel_i,
   input wire logic sfr_bit_val_i,
   output logic [p1g_pkg::P1G_PIN_W-1:0] sfr_rdata_o,
   output logic sfr_rvalid_o,
   input wire logic [p1g_pkg::P1G_PIN_W-1:0] pin_in_i,
   output logic [p1g_pkg::P1G_PIN_W-1:0] pin_out_o,
   output logic [p1g_pkg::P1G_PIN_W-1:0] pin_oe_o,
   input wire logic [p1g_pkg::P1G_PIN_W-1:0] mask_i,
   output logic [p1g_pkg::P1G_PIN_W-1:0] compare_level_o,
   output logic mismatch_o
);
   import p1g_pkg::*;

   // ****************************************************************
   // decode helper
   // ****************************************************************
   // paged registers answer only on the config page; others on any page
   function automatic logic reg_hit(input logic [P1G_ADDR_W-1:0] addr,
                                    input logic [P1G_PAGE_W-1:0] page,
                                    input logic [P1G_ADDR_W-1:0] reg_addr,
                                    input logic paged);
      reg_hit = (addr == reg_addr) && (!paged || (page == P1G_PAGE_CFG));
   endfunction : reg_hit

   logic [P1G_PIN_W-1:0] cmp_level_r;
   logic [P1G_PIN_W-1:0] cmp_level_nxt;
   logic [P1G_PIN_W-1:0] pin_latch_r;
   logic [P1G_PIN_W-1:0] pin_latch_nxt;
   logic [P1G_PIN_W-1:0] ana_dig_r;
   logic [P1G_PIN_W-1:0] ana_dig_nxt;
   logic [P1G_PIN_W-1:0] out_type_r;
   logic [P1G_PIN_W-1:0] out_type_nxt;
   logic [P1G_PIN_W-1:0] pin_samp_r;
   logic [P1G_PIN_W-1:0] pin_samp_nxt;
   logic [P1G_PIN_W-1:0] rdata_r;
   logic [P1G_PIN_W-1:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic mismatch_r;
   logic mismatch_nxt;
   logic hit_latch;
   logic hit_out_type;
   logic hit_ana_dig;
   logic hit_cmp;
   logic [P1G_PIN_W-1:0] bit_onehot;

   // address decode for all four registers
   always_comb begin
      hit_latch = reg_hit(sfr_addr_i, sfr_page_i, P1G_ADDR_PIN_LATCH, 1'b0);
      hit_out_type = reg_hit(sfr_addr_i, sfr_page_i, P1G_ADDR_OUT_TYPE, 1'b1);
      hit_ana_dig = reg_hit(sfr_addr_i, sfr_page_i, P1G_ADDR_ANA_DIG, 1'b1);
      hit_cmp = reg_hit(sfr_addr_i, sfr_page_i, P1G_ADDR_CMP_LEVEL, 1'b1);
      bit_onehot = P1G_PIN_W'(1) << sfr_bit_sel_i;
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   // byte writes win over a bit write on the same edge; the core never
   // issues both, so the order only fixes a defined answer
   always_comb begin
      cmp_level_nxt = cmp_level_r;
      ana_dig_nxt = ana_dig_r;
      out_type_nxt = out_type_r;
      pin_latch_nxt = pin_latch_r;
      if (sfr_wr_i && hit_cmp) begin
         cmp_level_nxt = sfr_wdata_i;
      end
      if (sfr_wr_i && hit_ana_dig) begin
         ana_dig_nxt = sfr_wdata_i;
      end
      if (sfr_wr_i && hit_out_type) begin
         out_type_nxt = sfr_wdata_i;
      end
      // analog pins keep their latch so a later switch to digital is clean
      if (sfr_bit_wr_i && hit_latch && ana_dig_r[sfr_bit_sel_i]) begin
         pin_latch_nxt = sfr_bit_val_i ? (pin_latch_r | bit_onehot)
                                       : (pin_latch_r & ~bit_onehot);
      end
      if (sfr_wr_i && hit_latch) begin
         pin_latch_nxt = (sfr_wdata_i & ana_dig_r) | (pin_latch_r & ~ana_dig_r);
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cmp_level_r <= P1G_RST_CMP_LEVEL;
         pin_latch_r <= P1G_RST_PIN_LATCH;
         ana_dig_r <= P1G_RST_ANA_DIG;
         out_type_r <= P1G_RST_OUT_TYPE;
      end else begin
         cmp_level_r <= cmp_level_nxt;
         pin_latch_r <= pin_latch_nxt;
         ana_dig_r <= ana_dig_nxt;
         out_type_r <= out_type_nxt;
      end
   end

   // ****************************************************************
   // pin sampling, read port and mismatch
   // ****************************************************************
   // a latch read shows pin levels, so a pin held low by the board
   // reads low even when its latch is high
   always_comb begin
      pin_samp_nxt = pin_in_i;
      rvalid_nxt = sfr_rd_i;
      rdata_nxt = P1G_RDATA_NONE;
      if (sfr_rd_i) begin
         if (hit_latch) begin
            rdata_nxt = pin_samp_r;
         end else if (hit_cmp) begin
            rdata_nxt = cmp_level_r;
         end else if (hit_ana_dig) begin
            rdata_nxt = ana_dig_r;
         end else if (hit_out_type) begin
            rdata_nxt = out_type_r;
         end else begin
            rdata_nxt = P1G_RDATA_NONE;
         end
      end
      mismatch_nxt = |((pin_samp_r ^ cmp_level_r) & mask_i);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_samp_r <= P1G_RST_PIN_LATCH;
         rdata_r <= P1G_RDATA_NONE;
         rvalid_r <= 1'b0;
         mismatch_r <= 1'b0;
      end else begin
         pin_samp_r <= pin_samp_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         mismatch_r <= mismatch_nxt;
      end
   end

   // ****************************************************************
   // pad cells
   // ****************************************************************
   for (genvar gi = 0; gi < P1G_PIN_W; gi++) begin : g_pad
      p1g_pad_cfg_s cfg;
      assign cfg = '{latch: pin_latch_r[gi], digital: ana_dig_r[gi],
                     push_pull: out_type_r[gi]};
      p1g_pad_cell u_pad (
         .clk_i(clk_i),
         .sys_rst_i(sys_rst_i),
         .cfg_i(cfg),
         .pad_out_o(pin_out_o[gi]),
         .pad_oe_o(pin_oe_o[gi])
      );
   end

   assign sfr_rdata_o = rdata_r;
   assign sfr_rvalid_o = rvalid_r;
   assign compare_level_o = cmp_level_r;
   assign mismatch_o = mismatch_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_match_write;
      @(posedge clk_i) disable iff (sys_rst_i)
      (sfr_wr_i && sfr_addr_i == P1G_ADDR_CMP_LEVEL && sfr_page_i == P1G_PAGE_CFG)
         |=> compare_level_o == $past(sfr_wdata_i);
   endproperty
   a_match_write: assert property (p_match_write)
      else $error("match register write not stored");

   property p_match_reset;
      @(posedge clk_i) $past(sys_rst_i) && !sys_rst_i |-> compare_level_o == P1G_RST_CMP_LEVEL;
   endproperty
   a_match_reset: assert property (p_match_reset)
      else $error("match register reset value wrong");

   property p_latch_digital_only;
      @(posedge clk_i) disable iff (sys_rst_i)
      (sfr_wr_i && sfr_addr_i == P1G_ADDR_PIN_LATCH)
         |=> ((pin_latch_r ^ $past(sfr_wdata_i)) & $past(ana_dig_r)) == 8'h00
             && ((pin_latch_r ^ $past(pin_latch_r)) & ~$past(ana_dig_r)) == 8'h00;
   endproperty
   a_latch_digital_only: assert property (p_latch_digital_only)
      else $error("latch write touched wrong pins");

   property p_latch_read_pins;
      @(posedge clk_i) disable iff (sys_rst_i)
      // pins pass the sample flop before the read flop, so data is two edges old
      (sfr_rd_i && sfr_addr_i == P1G_ADDR_PIN_LATCH)
         |=> sfr_rvalid_o && sfr_rdata_o == $past(pin_in_i, 2);
   endproperty
   a_latch_read_pins: assert property (p_latch_read_pins)
      else $error("latch read did not return pin levels");

   property p_drive_rule;
      @(posedge clk_i) disable iff (sys_rst_i)
      1'b1 |=> pin_oe_o == ($past(ana_dig_r) & (~$past(pin_latch_r) | $past(out_type_r)))
               && ((pin_oe_o & ~pin_out_o) == (pin_oe_o & ~$past(pin_latch_r)));
   endproperty
   a_drive_rule: assert property (p_drive_rule)
      else $error("pin drive does not follow latch and output mode");

   property p_bit_write;
      @(posedge clk_i) disable iff (sys_rst_i)
      (sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i == P1G_ADDR_PIN_LATCH
       && ana_dig_r[sfr_bit_sel_i])
         |=> pin_latch_r[$past(sfr_bit_sel_i)] == $past(sfr_bit_val_i)
             && $countones(pin_latch_r ^ $past(pin_latch_r)) <= 1;
   endproperty
   a_bit_write: assert property (p_bit_write)
      else $error("bit write to latch changed wrong bits");

   property p_analog_quiet;
      @(posedge clk_i) disable iff (sys_rst_i)
      1'b1 |=> (pin_oe_o & ~$past(ana_dig_r)) == 8'h00;
   endproperty
   a_analog_quiet: assert property (p_analog_quiet)
      else $error("analog pin is being driven");

   property p_mode_reset;
      @(posedge clk_i) $past(sys_rst_i) && !sys_rst_i
         |-> ana_dig_r == P1G_RST_ANA_DIG && out_type_r == P1G_RST_OUT_TYPE
             && pin_latch_r == P1G_RST_PIN_LATCH;
   endproperty
   a_mode_reset: assert property (p_mode_reset)
      else $error("mode register reset value wrong");

   property p_out_type_write;
      @(posedge clk_i) disable iff (sys_rst_i)
      (sfr_wr_i && sfr_addr_i == P1G_ADDR_OUT_TYPE && sfr_page_i != P1G_PAGE_CFG)
         |=> $stable(out_type_r);
   endproperty
   a_out_type_write: assert property (p_out_type_write)
      else $error("output mode written from wrong page");

   property p_mask_excludes;
      @(posedge clk_i) disable iff (sys_rst_i)
      (mask_i == 8'h00) |=> !mismatch_o;
   endproperty
   a_mask_excludes: assert property (p_mask_excludes)
      else $error("mismatch raised with all pins masked");

   property p_mismatch_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      // the compare flop sees match and mask one edge after the pin, so both
      // must hold still across that edge
      (((pin_in_i ^ compare_level_o) & mask_i) != 8'h00)
         ##1 ($stable(mask_i) && $stable(compare_level_o)) |=> mismatch_o;
   endproperty
   a_mismatch_hold: assert property (p_mismatch_hold)
      else $error("mismatch missed a differing unmasked pin");

   property p_mismatch_clear;
      @(posedge clk_i) disable iff (sys_rst_i)
      (((pin_in_i ^ compare_level_o) & mask_i) == 8'h00)
         ##1 ($stable(mask_i) && $stable(compare_level_o)) |=> !mismatch_o;
   endproperty
   a_mismatch_clear: assert property (p_mismatch_clear)
      else $error("mismatch raised while unmasked pins agree");

   property p_read_valid;
      @(posedge clk_i) disable iff (sys_rst_i)
      1'b1 |=> sfr_rvalid_o == $past(sfr_rd_i);
   endproperty
   a_read_valid: assert property (p_read_valid)
      else $error("read valid does not follow read strobe");

   // reads outside the map, or of a paged register off its page, return zero
   property p_unmapped_read;
      @(posedge clk_i) disable iff (sys_rst_i)
      (sfr_rd_i && sfr_addr_i != P1G_ADDR_PIN_LATCH
       && (sfr_page_i != P1G_PAGE_CFG || (sfr_addr_i != P1G_ADDR_CMP_LEVEL
           && sfr_addr_i != P1G_ADDR_ANA_DIG && sfr_addr_i != P1G_ADDR_OUT_TYPE)))
         |=> sfr_rdata_o == P1G_RDATA_NONE;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read returned data");

   property p_bit_write_analog;
      @(posedge clk_i) disable iff (sys_rst_i)
      (sfr_bit_wr_i && !sfr_wr_i && !ana_dig_r[sfr_bit_sel_i]) |=> $stable(pin_latch_r);
   endproperty
   a_bit_write_analog: assert property (p_bit_write_analog)
      else $error("bit write changed an analog pin latch");

   // bit access exists only at the latch address
   property p_bit_write_other;
      @(posedge clk_i) disable iff (sys_rst_i)
      (sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i != P1G_ADDR_PIN_LATCH)
         |=> $stable(pin_latch_r) && $stable(out_type_r);
   endproperty
   a_bit_write_other: assert property (p_bit_write_other)
      else $error("bit write honoured off the latch address");

endmodule : p1g_port

// ### inc/p1g_pkg.sv
// p1g_pkg: register map, reset values and pad carrier for the port 1 slice.
// assumes an 8-bit special function register bus with a 4-bit page select.
package p1g_pkg;

   // ****************************************************************
   // widths and register map
   // ****************************************************************
   localparam int P1G_PIN_W = 8;
   localparam int P1G_ADDR_W = 8;
   localparam int P1G_PAGE_W = 4;
   localparam logic [P1G_PAGE_W-1:0] P1G_PAGE_CFG = 4'hF;
   localparam logic [P1G_ADDR_W-1:0] P1G_ADDR_PIN_LATCH = 8'h90;
   localparam logic [P1G_ADDR_W-1:0] P1G_ADDR_OUT_TYPE = 8'hDC;
   localparam logic [P1G_ADDR_W-1:0] P1G_ADDR_ANA_DIG = 8'hED;
   localparam logic [P1G_ADDR_W-1:0] P1G_ADDR_CMP_LEVEL = 8'hF5;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [P1G_PIN_W-1:0] P1G_RST_PIN_LATCH = 8'hFF;
   localparam logic [P1G_PIN_W-1:0] P1G_RST_OUT_TYPE = 8'h00;
   localparam logic [P1G_PIN_W-1:0] P1G_RST_ANA_DIG = 8'hFF;
   localparam logic [P1G_PIN_W-1:0] P1G_RST_CMP_LEVEL = 8'hFF;
   localparam logic [P1G_PIN_W-1:0] P1G_RDATA_NONE = 8'h00;

   // per-pin configuration handed to a pad cell
   typedef struct packed {
      logic latch;
      logic digital;
      logic push_pull;
   } p1g_pad_cfg_s;

endpackage : p1g_pkg

// ### verilog/p1g_pad_cell.sv
// p1g_pad_cell: output driver control for one port pin.
// assumes the pad wire is resolved outside from pad_out_o and pad_oe_o.
`timescale 1ns/1ns
module p1g_pad_cell (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire p1g_pkg::p1g_pad_cfg_s cfg_i,
   output logic pad_out_o,
   output logic pad_oe_o
);
   import p1g_pkg::*;

   logic out_r;
   logic out_nxt;
   logic oe_r;
   logic oe_nxt;

   // ****************************************************************
   // drive decision
   // ****************************************************************
   // analog pins never drive; a high latch on open-drain only releases
   always_comb begin
      out_nxt = cfg_i.latch;
      oe_nxt = cfg_i.digital & (~cfg_i.latch | cfg_i.push_pull);
   end

   // registered so the pad never sees a decode glitch
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         out_r <= P1G_RST_PIN_LATCH[0];
         oe_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign pad_out_o = out_r;
   assign pad_oe_o = oe_r;

endmodule : p1g_pad_cell

// ### verif/p1g_pin_model.sv
// p1g_pin_model: eight board pins, each with a weak pull-up.
// assumes the bench may hold a released pin with an external driver.
`timescale 1ns/1ns
module p1g_pin_model (
   input wire logic [7:0] pin_out_i,
   input wire logic [7:0] pin_oe_i,
   input wire logic [7:0] ext_en_i,
   input wire logic [7:0] ext_val_i,
   output logic [7:0] pin_lvl_o
);
   // ****************************************************************
   // pad resolution
   // ****************************************************************
   // the port driver wins; a released pin floats high unless the board holds it
   assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & (~ext_en_i | ext_val_i));
endmodule : p1g_pin_model

// ### verif/p1g_port_bench.sv
// p1g_port_bench: self-checking bench for the port 1 register slice.
// assumes p1g_pkg is compiled first and p1g_pin_model closes the pin loop.
`timescale 1ns/1ns
module p1g_port_bench;
   import p1g_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [3:0] page = 4'h0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic bwr_s = 1'b0;
   logic [2:0] bsel = 3'h0;
   logic bval = 1'b0;
   logic [7:0] mask = 8'h00;
   logic [7:0] ext_en = 8'h00;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] rdata, pin_lvl, pin_out, pin_oe, cmp_lvl;
   logic rvalid, mismatch;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;

   // ****************************************************************
   // clock, pins and device
   // ****************************************************************
   always #5 clk_i = ~clk_i;
   p1g_pin_model pins (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pin_lvl_o(pin_lvl));
   p1g_port DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(addr),
      .sfr_page_i(page), .sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_wdata_i(wdata),
      .sfr_bit_wr_i(bwr_s), .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval),
      .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid), .pin_in_i(pin_lvl),
      .pin_out_o(pin_out), .pin_oe_o(pin_oe), .mask_i(mask),
      .compare_level_o(cmp_lvl), .mismatch_o(mismatch));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic final_report;
      if (num_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // inputs move 1 ns after the edge so the design never races the bench
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] d);
      addr = a;
      page = pg;
      wdata = d;
      wr_s = 1'b1;
      cyc(1);
      wr_s = 1'b0;
      cyc(1); // idle edge so a following call never re-raises the strobe at once
   endtask : wr

   task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
      addr = a;
      bsel = s;
      bval = v;
      bwr_s = 1'b1;
      cyc(1);
      bwr_s = 1'b0;
      cyc(1);
   endtask : bwr

   // answer stands for exactly one cycle after the taking edge
   task automatic rd(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] exp);
      addr = a;
      page = pg;
      rd_s = 1'b1;
      cyc(1);
      rd_s = 1'b0;
      chk("rvalid", {7'h00, rvalid}, 8'h01);
      chk("rdata", rdata, exp);
      cyc(1);
   endtask : rd

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      rd(8'hDC, 4'hF, 8'h00);
      rd(8'hED, 4'hF, 8'hFF);
      rd(8'hF5, 4'hF, 8'hFF);
      rd(8'h90, 4'h3, 8'hFF);
      chk("cmp_lvl", cmp_lvl, 8'hFF);
      chk("pin_out", pin_out, 8'hFF);
      chk("pin_oe", pin_oe, 8'h00);
   endtask : t_reset

   // paged registers ignore other pages; unmapped reads give zero
   task automatic t_paging;
      wr(8'hF5, 4'h0, 8'h00);
      rd(8'hF5, 4'hF, 8'hFF);
      rd(8'hF5, 4'h0, 8'h00);
      rd(8'h91, 4'hF, 8'h00);
      wr(8'hF5, 4'hF, 8'h5A);
      cyc(1);
      chk("cmp_lvl", cmp_lvl, 8'h5A);
   endtask : t_paging

   task automatic t_latch;
      wr(8'h90, 4'h2, 8'h5A);
      cyc(1);
      chk("pin_out", pin_out, 8'h5A);
      chk("pin_oe", pin_oe, 8'hA5);
      cyc(2);
      rd(8'h90, 4'hF, 8'h5A);
      ext_en = 8'h5A;
      cyc(2);
      rd(8'h90, 4'h0, 8'h00);
      ext_en = 8'h00;
      wr(8'hDC, 4'hF, 8'hFF);
      cyc(1);
      chk("pin_oe", pin_oe, 8'hFF);
      rd(8'hDC, 4'hF, 8'hFF);
   endtask : t_latch

   task automatic t_bits;
      bwr(8'h90, 3'h3, 1'b0);
      bwr(8'h90, 3'h0, 1'b1);
      bwr(8'hDC, 3'h0, 1'b0);
      cyc(1);
      chk("pin_out", pin_out, 8'h53);
      rd(8'hDC, 4'hF, 8'hFF);
   endtask : t_bits

   // analog pins keep their latch and never drive
   task automatic t_analog;
      wr(8'hED, 4'hF, 8'hF0);
      wr(8'h90, 4'h1, 8'h00);
      bwr(8'h90, 3'h0, 1'b0);
      cyc(1);
      chk("pin_oe", pin_oe, 8'hF0);
      chk("pin_out", pin_out, 8'h03);
      rd(8'hED, 4'hF, 8'hF0);
      wr(8'hED, 4'hF, 8'hFF);
      wr(8'hDC, 4'hF, 8'h00);
      wr(8'h90, 4'h0, 8'hFF);
   endtask : t_analog

   task automatic t_match;
      wr(8'hF5, 4'hF, 8'hFF);
      mask = 8'h01;
      cyc(2);
      chk("mismatch", {7'h00, mismatch}, 8'h00);
      ext_en = 8'h01;
      cyc(2);
      chk("mismatch", {7'h00, mismatch}, 8'h01);
      mask = 8'h02;
      cyc(1);
      chk("mismatch", {7'h00, mismatch}, 8'h00);
      mask = 8'h01;
      wr(8'hF5, 4'hF, 8'hFE);
      cyc(1);
      chk("mismatch", {7'h00, mismatch}, 8'h00);
      ext_en = 8'h00;
      cyc(2);
      chk("mismatch", {7'h00, mismatch}, 8'h01);
      cyc(3);
      chk("mismatch", {7'h00, mismatch}, 8'h01);
   endtask : t_match

   // ****************************************************************
   // main sequence and hang guard
   // ****************************************************************
   always @(posedge clk_i) begin
      cycles++;
      if (cycles >= 2000) begin
         num_errors++;
         final_report();
      end
   end

   initial begin
      cyc(8);
      sys_rst_i = 1'b0;
      cyc(1);
      t_reset();
      t_paging();
      t_latch();
      t_bits();
      t_analog();
      t_match();
      final_report();
   end
endmodule : p1g_port_bench
